/* shared/cad_pkg.sv */
// constants and state type for the combined activity decision block
package cad_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CAD_OFS_CTRL = 8'h00;
  localparam logic [7:0] CAD_OFS_THR_LT = 8'h04;
  localparam logic [7:0] CAD_OFS_THR_LF = 8'h08;
  localparam logic [7:0] CAD_OFS_STATUS = 8'h0c;
  localparam logic [7:0] CAD_OFS_FEATURE = 8'h10;

  // ----------------------------------------------------------------
  // field layout and encodings
  // ----------------------------------------------------------------
  localparam int CAD_CTRL_RATE_LSB = 0;
  localparam logic [1:0] CAD_RATE_OTHER = 2'h0;
  localparam logic [1:0] CAD_RATE_16K = 2'h1;
  localparam logic [1:0] CAD_RATE_32K = 2'h2;
  localparam int CAD_ST_MERGED = 0;
  localparam int CAD_ST_SILENCE = 1;
  localparam int CAD_ST_FORCED_LSB = 8;
  localparam int CAD_ST_UPD_LSB = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CAD_RST_RATE = CAD_RATE_16K;
  localparam logic [15:0] CAD_RST_THR_LT = 16'h0800;
  localparam logic [15:0] CAD_RST_THR_LF = 16'h0800;

  // ----------------------------------------------------------------
  // decision thresholds, unsigned q8.8; continuity limits in frames
  // ----------------------------------------------------------------
  localparam logic [15:0] CAD_T_FSNR = 16'h0033;      // 0.2
  localparam logic [15:0] CAD_T_LF_KEEP = 16'h0a80;   // 10.5
  localparam logic [15:0] CAD_T_LF_OTHER = 16'h0c80;  // 12.5
  localparam logic [15:0] CAD_T_FLUX_HI = 16'h0233;   // 2.2
  localparam logic [15:0] CAD_T_FLUX_HI_O = 16'h0200; // 2.0
  localparam logic [15:0] CAD_T_FLUX_LO = 16'h0180;   // 1.5
  localparam logic [15:0] CAD_CONT_HI = 16'h0028;     // 40 frames
  localparam logic [15:0] CAD_CONT_HI_O = 16'h001e;   // 30 frames

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  localparam logic [9:0] CAD_UPD_MAX = 10'h3e8;       // 1000
  localparam logic [9:0] CAD_UPD_EARLY = 10'h00c;     // 12
  localparam logic [7:0] CAD_FORCED_MIN = 8'h14;      // 20
  localparam logic [15:0] CAD_CONT_MAX = 16'hffff;

  typedef struct packed {
    logic [1:0] rate;
    logic [15:0] thr_lt;
    logic [15:0] thr_lf;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic merged;
    logic merged_valid;
    logic silence;
    logic first;
    logic [15:0] cont_cnt;
    logic [9:0] upd_cnt;
    logic [7:0] forced;
    logic [15:0] prev_energy;
    logic prev_bgupd;
    logic prev_tonal;
    logic [15:0] bg_m1;
    logic [15:0] bg_m2;
    logic [15:0] flux;
  } cad_state_t;

  localparam cad_state_t CAD_RST_STATE = '{
    rate: CAD_RST_RATE,
    thr_lt: CAD_RST_THR_LT,
    thr_lf: CAD_RST_THR_LF,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    merged: 1'b0,
    merged_valid: 1'b0,
    silence: 1'b0,
    first: 1'b1,
    cont_cnt: 16'h0000,
    upd_cnt: 10'h000,
    forced: 8'h00,
    prev_energy: 16'h0000,
    prev_bgupd: 1'b0,
    prev_tonal: 1'b0,
    bg_m1: 16'h0000,
    bg_m2: 16'h0000,
    flux: 16'h0000
  };

endpackage

/* rtl/cad_decision.sv */
// combined activity decision with apb register access
//
// How it works
// - noise is silence only above both thresholds
// - 16/32 kHz: start from secondary flag
// - silence, fsnr over 0.2, start zero: primary
// - silence and lf snr at least 10.5: keep start
// - strong flux, long activity or tonal: or flags
// - fallback: 32k silence primary else start; 16k primary
// - other rates: start secondary, branch on noise type
// - other silence: lf over 12.5, not tonal: primary
// - other non-silence: flux/activity/tonal or, else start
// - background update count saturates at 1000
// - early active frame loads forced count max(20,hang)
// - inactive with forced count: force active, decrement
// - previous background energy from history and flags
// - flux from previous background and current energy
// - continuous count zero first, follows previous flag
`timescale 1ns/1ps
`default_nettype none

module cad_decision (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_strobe,
  input wire logic primary_activity_flag,
  input wire logic secondary_activity_flag,
  input wire logic [15:0] original_longterm_snr,
  input wire logic [15:0] smoothed_longterm_freq_snr,
  input wire logic [15:0] freq_snr,
  input wire logic [15:0] frame_energy,
  input wire logic tonality_flag,
  input wire logic bg_update_flag,
  input wire logic [7:0] hangover_count,
  output logic merged_activity_flag,
  output logic merged_valid,
  output logic noise_is_silence
);

  cad_pkg::cad_state_t st_r;
  cad_pkg::cad_state_t st_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [17:0] bg_sum;
    logic [15:0] bg_prev;
    logic [15:0] cont;
    logic [9:0] upd;
    logic [7:0] fc;
    logic sil;
    logic init;
    logic m;
    logic or_hi;
    logic or_other;
    logic band_16_32;
    logic hit;
    logic [31:0] rd;
    bg_sum = 18'h00000;
    bg_prev = 16'h0000;
    cont = 16'h0000;
    upd = 10'h000;
    fc = 8'h00;
    sil = 1'b0;
    init = 1'b0;
    m = 1'b0;
    or_hi = 1'b0;
    or_other = 1'b0;
    band_16_32 = 1'b0;
    hit = 1'b0;
    rd = 32'h0000_0000;
    st_nxt = st_r;
    st_nxt.merged_valid = 1'b0;

    // --------------------------------------------------------------
    // apb slave: answer one cycle into the access phase
    // --------------------------------------------------------------
    if (psel && penable && st_r.pready) begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (pwrite) begin
        if (paddr == cad_pkg::CAD_OFS_CTRL) begin
          st_nxt.rate = pwdata[cad_pkg::CAD_CTRL_RATE_LSB +: 2];
        end else if (paddr == cad_pkg::CAD_OFS_THR_LT) begin
          st_nxt.thr_lt = pwdata[15:0];
        end else if (paddr == cad_pkg::CAD_OFS_THR_LF) begin
          st_nxt.thr_lf = pwdata[15:0];
        end
      end
    end else if (psel && penable) begin
      hit = 1'b1;
      if (paddr == cad_pkg::CAD_OFS_CTRL) begin
        rd[cad_pkg::CAD_CTRL_RATE_LSB +: 2] = st_r.rate;
      end else if (paddr == cad_pkg::CAD_OFS_THR_LT) begin
        rd[15:0] = st_r.thr_lt;
      end else if (paddr == cad_pkg::CAD_OFS_THR_LF) begin
        rd[15:0] = st_r.thr_lf;
      end else if (paddr == cad_pkg::CAD_OFS_STATUS && !pwrite) begin
        rd[cad_pkg::CAD_ST_MERGED] = st_r.merged;
        rd[cad_pkg::CAD_ST_SILENCE] = st_r.silence;
        rd[cad_pkg::CAD_ST_FORCED_LSB +: 8] = st_r.forced;
        rd[cad_pkg::CAD_ST_UPD_LSB +: 10] = st_r.upd_cnt;
      end else if (paddr == cad_pkg::CAD_OFS_FEATURE && !pwrite) begin
        rd[15:0] = st_r.flux;
        rd[31:16] = st_r.cont_cnt;
      end else begin
        // unmapped or write to a read-only word: error, no effect
        hit = 1'b0;
      end
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !hit;
      st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
    end else begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // --------------------------------------------------------------
    // per-frame decision
    // --------------------------------------------------------------
    if (frame_strobe) begin
      // previous frame's background energy; a tonal or non-update frame holds the old level
      if (st_r.prev_bgupd && !st_r.prev_tonal) begin
        bg_sum = {1'b0, st_r.prev_energy, 1'b0} + {2'b00, st_r.bg_m1} + {2'b00, st_r.bg_m2};
        bg_prev = bg_sum[17:2];
      end else begin
        bg_prev = st_r.bg_m1;
      end
      // flux saturates at zero when energy sits below the background
      if (frame_energy > bg_prev) begin
        st_nxt.flux = frame_energy - bg_prev;
      end else begin
        st_nxt.flux = 16'h0000;
      end
      st_nxt.bg_m2 = st_r.bg_m1;
      st_nxt.bg_m1 = bg_prev;
      st_nxt.prev_energy = frame_energy;
      st_nxt.prev_bgupd = bg_update_flag;
      st_nxt.prev_tonal = tonality_flag;

      if (st_r.first) begin
        cont = 16'h0000;
      end else if (st_r.merged) begin
        cont = (st_r.cont_cnt == cad_pkg::CAD_CONT_MAX) ? st_r.cont_cnt : st_r.cont_cnt + 16'h0001;
      end else begin
        cont = 16'h0000;
      end

      sil = (original_longterm_snr > st_r.thr_lt) && (smoothed_longterm_freq_snr > st_r.thr_lf);

      or_hi = (st_nxt.flux > cad_pkg::CAD_T_FLUX_HI) ||
              ((st_nxt.flux > cad_pkg::CAD_T_FLUX_LO) && (cont > cad_pkg::CAD_CONT_HI)) ||
              tonality_flag;
      or_other = (st_nxt.flux > cad_pkg::CAD_T_FLUX_HI_O) ||
                 ((st_nxt.flux > cad_pkg::CAD_T_FLUX_LO) && (cont > cad_pkg::CAD_CONT_HI_O)) ||
                 tonality_flag;
      band_16_32 = (st_r.rate == cad_pkg::CAD_RATE_16K) || (st_r.rate == cad_pkg::CAD_RATE_32K);
      init = secondary_activity_flag;

      if (band_16_32) begin
        if (sil && (freq_snr > cad_pkg::CAD_T_FSNR) && !init) begin
          m = primary_activity_flag;
        end else if (sil && (smoothed_longterm_freq_snr >= cad_pkg::CAD_T_LF_KEEP)) begin
          m = init;
        end else if (or_hi) begin
          m = primary_activity_flag | secondary_activity_flag;
        end else if (st_r.rate == cad_pkg::CAD_RATE_32K) begin
          m = sil ? primary_activity_flag : init;
        end else begin
          m = primary_activity_flag;
        end
      end else if (sil) begin
        if ((smoothed_longterm_freq_snr > cad_pkg::CAD_T_LF_OTHER) && !tonality_flag) begin
          m = primary_activity_flag;
        end else begin
          m = init;
        end
      end else begin
        m = or_other ? (primary_activity_flag | secondary_activity_flag) : init;
      end

      upd = st_r.upd_cnt;
      if (bg_update_flag && (st_r.upd_cnt < cad_pkg::CAD_UPD_MAX)) begin
        upd = st_r.upd_cnt + 10'h001;
      end

      fc = st_r.forced;
      if (secondary_activity_flag && (upd < cad_pkg::CAD_UPD_EARLY)) begin
        fc = (hangover_count > cad_pkg::CAD_FORCED_MIN) ? hangover_count : cad_pkg::CAD_FORCED_MIN;
      end
      // forcing covers the start-up period before the noise estimate settles
      if (!m && (fc != 8'h00)) begin
        m = 1'b1;
        fc = fc - 8'h01;
      end

      st_nxt.silence = sil;
      st_nxt.cont_cnt = cont;
      st_nxt.upd_cnt = upd;
      st_nxt.forced = fc;
      st_nxt.merged = m;
      st_nxt.merged_valid = 1'b1;
      st_nxt.first = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= cad_pkg::CAD_RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign merged_activity_flag = st_r.merged;
  assign merged_valid = st_r.merged_valid;
  assign noise_is_silence = st_r.silence;

endmodule // cad_decision

`default_nettype wire

/* dv/cad_decision_properties.sv */
// port assertions for the combined activity decision block
`timescale 1ns/1ps
`default_nettype none
module cad_decision_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_strobe,
  input wire logic primary_activity_flag,
  input wire logic secondary_activity_flag,
  input wire logic [15:0] original_longterm_snr,
  input wire logic merged_activity_flag,
  input wire logic merged_valid,
  input wire logic noise_is_silence
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && !pready; endsequence
  a_ready_late: assert property (s_setup ##1 s_access |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
  a_err_unmapped: assert property (pready && paddr > 8'h10 |-> pslverr) else $error("no pslverr");
  a_valid_follows: assert property (frame_strobe |=> merged_valid) else $error("no valid");
  a_valid_cause: assert property (merged_valid |-> $past(frame_strobe)) else $error("stray valid");
  a_flag_held: assert property (!frame_strobe |=> $stable(merged_activity_flag)
    && $stable(noise_is_silence)) else $error("flag moved");
  // both detectors active leaves no branch that can clear the merged flag
  a_both_active: assert property (frame_strobe && primary_activity_flag && secondary_activity_flag
    |=> merged_activity_flag) else $error("merge lost");
  a_low_snr: assert property (frame_strobe && original_longterm_snr == 16'h0000
    |=> !noise_is_silence) else $error("silence at zero snr");
endmodule // cad_decision_props
bind cad_decision cad_decision_props u_props (.pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr,
  .frame_strobe, .primary_activity_flag, .secondary_activity_flag, .original_longterm_snr,
  .merged_activity_flag, .merged_valid, .noise_is_silence);
`default_nettype wire

/* dv/cad_upstream_model.sv */
// behavioural model of the upstream feature and detector stages
`timescale 1ns/1ps
`default_nettype none
module cad_upstream_model (
  input wire logic pclk,
  output logic frame_strobe,
  output logic primary_activity_flag,
  output logic secondary_activity_flag,
  output logic [15:0] original_longterm_snr,
  output logic [15:0] smoothed_longterm_freq_snr,
  output logic [15:0] freq_snr,
  output logic [15:0] frame_energy,
  output logic tonality_flag,
  output logic bg_update_flag,
  output logic [7:0] hangover_count
);
  logic [75:0] feat;
  assign {primary_activity_flag, secondary_activity_flag, tonality_flag, bg_update_flag, original_longterm_snr,
    smoothed_longterm_freq_snr, freq_snr, frame_energy, hangover_count} = feat;
  initial begin
    frame_strobe = 1'b0;
    feat = '0;
  end
  task automatic send(input logic [75:0] f);
    @(posedge pclk);
    frame_strobe <= 1'b1;
    feat <= f;
    @(posedge pclk);
    frame_strobe <= 1'b0;
    // features are stale after the strobe: inverting them exposes late sampling
    feat <= ~f;
  endtask
endmodule // cad_upstream_model
`default_nettype wire

/* dv/combined_activity_decision_test.sv */
// self-checking bench for the combined activity decision block
`timescale 1ns/1ps
`default_nettype none
module combined_activity_decision_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic frame_strobe, primary_activity_flag, secondary_activity_flag, tonality_flag, bg_update_flag;
  logic [15:0] original_longterm_snr, smoothed_longterm_freq_snr, freq_snr, frame_energy, cont;
  logic [7:0] hangover_count, frc;
  logic merged_activity_flag, merged_valid, noise_is_silence, pm, first_f, sil;
  logic [9:0] upd;
  logic [15:0] bgm1, bgm2, pe, flx;
  logic pb, pt;
  logic [1:0] exp_q[$];
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  cad_decision u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .frame_strobe, .primary_activity_flag, .secondary_activity_flag, .original_longterm_snr,
    .smoothed_longterm_freq_snr, .freq_snr, .frame_energy, .tonality_flag, .bg_update_flag, .hangover_count,
    .merged_activity_flag, .merged_valid, .noise_is_silence);
  cad_upstream_model u_up (.pclk, .frame_strobe, .primary_activity_flag, .secondary_activity_flag,
    .original_longterm_snr, .smoothed_longterm_freq_snr, .freq_snr, .frame_energy, .tonality_flag,
    .bg_update_flag, .hangover_count);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic decide(logic p, s, t, sl, logic [15:0] lf, fs, fx, cn, logic [1:0] r);
    if (r == 2'h1 || r == 2'h2) begin
      if (sl && fs > cad_pkg::CAD_T_FSNR && !s) return p;
      if (sl && lf >= cad_pkg::CAD_T_LF_KEEP) return s;
      if (fx > cad_pkg::CAD_T_FLUX_HI || (fx > cad_pkg::CAD_T_FLUX_LO && cn > cad_pkg::CAD_CONT_HI) || t) return p | s;
      return (r == 2'h2 && !sl) ? s : p;
    end
    if (sl) return (lf > cad_pkg::CAD_T_LF_OTHER && !t) ? p : s;
    return (fx > cad_pkg::CAD_T_FLUX_HI_O || (fx > cad_pkg::CAD_T_FLUX_LO && cn > cad_pkg::CAD_CONT_HI_O) || t)
      ? p | s : s;
  endfunction
  task automatic frame(input logic [1:0] r);
    logic p, s, t, b, m;
    logic [15:0] l1, l2, f, e;
    logic [7:0] h;
    logic [17:0] bs;
    {p, s} = 2'($urandom);
    t = $urandom_range(7) == 0;
    b = $urandom_range(7) != 0;
    l1 = ($urandom_range(7) == 0) ? 16'h0000 : 16'($urandom_range(16'h0d00));
    l2 = 16'($urandom_range(16'h0e00, 16'h0600));
    f = 16'($urandom_range(16'h0060));
    e = 16'($urandom_range(16'h0300));
    // background of the previous frame: quarter of twice its energy plus two older levels, else the old level when tonal or not updating
    bs = (pb && !pt) ? ({1'b0, pe, 1'b0} + {2'b00, bgm1} + {2'b00, bgm2}) : {bgm1, 2'b00};
    flx = (e > bs[17:2]) ? e - bs[17:2] : 16'h0000;
    bgm2 = bgm1;
    bgm1 = bs[17:2];
    pe = e;
    pb = b;
    pt = t;
    h = 8'($urandom_range(40));
    cont = first_f ? 16'h0000 : pm ? cont + 16'(cont != 16'hffff) : 16'h0000;
    first_f = 1'b0;
    sil = l1 > 16'h0a00 && l2 > cad_pkg::CAD_RST_THR_LF;
    m = decide(p, s, t, sil, l2, f, flx, cont, r);
    if (b && upd < cad_pkg::CAD_UPD_MAX) upd++;
    if (s && upd < cad_pkg::CAD_UPD_EARLY) frc = (h > cad_pkg::CAD_FORCED_MIN) ? h : cad_pkg::CAD_FORCED_MIN;
    if (!m && frc > 0) begin
      m = 1'b1;
      frc--;
    end
    pm = m;
    exp_q.push_back({m, sil});
    u_up.send({p, s, t, b, l1, l2, f, e, h});
  endtask
  always @(posedge pclk) begin
    if (merged_valid === 1'b1) begin
      if (exp_q.size() == 0) check("merged_valid", 32'h0, 32'h1);
      else check("merged", 32'(exp_q.pop_front()), {30'h0, merged_activity_flag, noise_is_silence});
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {cont, upd, frc, pm, first_f, sil} = {34'h0, 1'b0, 1'b1, 1'b0};
    {bgm1, bgm2, pe, flx, pb, pt} = 66'h0;
    void'($urandom(97641));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cad_pkg::CAD_OFS_CTRL, 32'h0);
    check("ctrl", 32'(cad_pkg::CAD_RST_RATE), rd);
    apb(1'b1, cad_pkg::CAD_OFS_THR_LT, 32'h0a00);
    apb(1'b0, cad_pkg::CAD_OFS_THR_LT, 32'h0);
    check("thr_lt", 32'h0a00, rd);
    apb(1'b1, cad_pkg::CAD_OFS_STATUS, 32'h1);
    check("ro_err", 32'h1, 32'(er));
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped_err", 32'h1, 32'(er));
    for (int i = 0; i < 1600; i++) begin
      if (i % 200 == 0) apb(1'b1, cad_pkg::CAD_OFS_CTRL, 32'(i / 200 % 4));
      frame(2'(i / 200 % 4));
    end
    repeat (3) @(posedge pclk);
    apb(1'b0, cad_pkg::CAD_OFS_STATUS, 32'h0);
    check("status", 32'({upd, frc, 6'h0, sil, pm}), rd);
    apb(1'b0, cad_pkg::CAD_OFS_FEATURE, 32'h0);
    check("feature", {cont, flx}, rd);
    complete_run();
  end
endmodule // combined_activity_decision_test
`default_nettype wire
